// file: scan_bus_ctrl_model.sv
`timescale 1ns/1ps
module scan_bus_ctrl_model
#(
	parameter real HALF_NS = 100.0
)
(
	// Scan pins toward the device
	output logic tck,
	output logic tms,
	output logic tdi,
	// Returned data
	input wire logic tdo,
	input wire logic tdoOe
);
	initial
	begin
		tck = 0;
		tms = 1;
		tdi = 1;
	end
	// Pins move only while the clock is low, so the rise always sees them settled
	task automatic step(input logic m, input logic d, output logic q, output logic oe);
		tms = m;
		tdi = d;
		#(HALF_NS);
		q = tdo;
		oe = tdoOe;
		tck = 1;
		#(HALF_NS);
		tck = 0;
	endtask
endmodule

// file: scan_tap_defs.vh
`ifndef SCAN_TAP_DEFS_VH
`define SCAN_TAP_DEFS_VH

// Instruction register
`define IR_WIDTH 8
`define IR_PARITY_BIT 7
`define IR_RESET_VALUE 8'hFF
// Status word fields
`define STAT_PERR_BIT 7
`define STAT_COND_BIT 3
`define STAT_ONE_BIT 0
// Opcodes
`define OP_EXTEST 8'h00
`define OP_INTEST 8'h03
`define OP_SAMPLE 8'h82
`define OP_COUNT_A 8'h88
`define OP_COUNT_B 8'h09
`define OP_CTRL_A 8'h8E
`define OP_CTRL_B 8'h0F
`define OP_CNT_SCAN 8'hFA
`define OP_CNT_READ 8'h7B
`define OP_IDB_SCAN 8'hFC
`define OP_IDB_READ 8'h7D
`define OP_SEL_SCAN 8'h7E
// Data register select codes
`define DR_BYPASS 3'd0
`define DR_BOUNDARY 3'd1
`define DR_CONTROL 3'd2
`define DR_COUNTER 3'd3
`define DR_IDBUS 3'd4
`define DR_SELECT 3'd5
// Data register lengths
`define BSR_WIDTH 8
`define CTRL_WIDTH 10
`define CNT_WIDTH 8
`define IDB_WIDTH 4
`define SEL_WIDTH 8
// Control register fields used here
`define CTRL_COND_MODE_LO 5
`define CTRL_COND_MODE_HI 6
`define CTRL_MASK_PERR_BIT 4
`define CTRL_COND_POL_BIT 7
`define CTRL_COND_EN_BIT 2
`define CTRL_COND_3ST_BIT 3
`define CTRL_DCI_POL_BIT 1
`define CTRL_DIR_BIT 9
`define CTRL_RESET_VALUE 10'h000
// Timing
`define TCK_PERIOD_NS 200
`define REF_PERIOD_NS 25
`define TCK_MIN_CYCLES ((`TCK_PERIOD_NS + `REF_PERIOD_NS - 1) / `REF_PERIOD_NS)

`endif

// file: scan_tap_instruction_decoder.v
`timescale 1ns/1ps
`include "scan_tap_defs.vh"

// Overview of operation
// - TMS high five cycles reaches reset
// - Controller starts in Test-Logic-Reset
// - Idle keeps registers; counter runs only there
// - Select states do nothing, exit next
// - Capture-DR selects register, maybe loads
// - Shift-DR shifts per cycle, not entry
// - TDO enabled at falling edge, LSB
// - Last shift into Exit1; TDO released
// - Exits reenter shift; pause keeps data
// - Parallel latches change only in Update-DR
// - Capture-IR loads status word
// - Status shows parity result and condition
// - Status bits: 7 error, 3 cond, 0 one
// - Shift-IR shifts; TDO driven at fall
// - Last IR shift into Exit1-IR; release
// - IR exits reenter shift; pause preserves
// - Instruction latches load only in Update-IR
// - Bit 7 even parity; error when odd
// - Condition output shows parity error option
// - Opcode decode selects boundary, control, counter
// - FC captures ID bus; 7D reads
// - Other opcodes select bypass register
// - Sample rising edge, drive falling edge
// - Test reset forces reset and values
module scan_tap_instruction_decoder
(
	// System
	input wire ref_clk,
	input wire sys_rst,
	// Scan pins from the bus controller
	input wire tck,
	input wire tms,
	input wire tdi,
	input wire trstN,
	output wire tdo,
	output wire tdoOe,
	// Condition pins
	input wire condition_input,
	output wire condition_output,
	output wire conditionOutputOe,
	// Identification bus
	input wire [`IDB_WIDTH-1:0] idBus,
	// Decoded instruction state
	output reg [2:0] drSelect_r,
	output reg testMode_r,
	output reg countMode_r,
	output reg parity_error_flag,
	output reg [`CTRL_WIDTH-1:0] ctrlOut_r,
	output reg [`SEL_WIDTH-1:0] selOut_r,
	output reg [`CNT_WIDTH-1:0] count_r,
	// Shifted-out word stream
	output wire wordValid,
	input wire wordReady,
	output wire [`IR_WIDTH-1:0] wordData
);

	localparam [15:0] S_TLR = 16'h0001;
	localparam [15:0] S_RTI = 16'h0002;
	localparam [15:0] S_SDR = 16'h0004;
	localparam [15:0] S_CDR = 16'h0008;
	localparam [15:0] S_SHDR = 16'h0010;
	localparam [15:0] S_E1DR = 16'h0020;
	localparam [15:0] S_PDR = 16'h0040;
	localparam [15:0] S_E2DR = 16'h0080;
	localparam [15:0] S_UDR = 16'h0100;
	localparam [15:0] S_SIR = 16'h0200;
	localparam [15:0] S_CIR = 16'h0400;
	localparam [15:0] S_SHIR = 16'h0800;
	localparam [15:0] S_E1IR = 16'h1000;
	localparam [15:0] S_PIR = 16'h2000;
	localparam [15:0] S_E2IR = 16'h4000;
	localparam [15:0] S_UIR = 16'h8000;

	// Two-flop synchronisers for the trstN, tck, tms, tdi and condition pins; idBus is used unsynchronised
	reg [5:0] sync1_r;
	reg [5:0] sync2_r;
	reg tckLast_r;
	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			sync1_r <= 6'h3F;
			sync2_r <= 6'h3F;
			tckLast_r <= 1'b1;
		end
		else
		begin
			sync1_r <= {trstN, tck, tms, tdi, condition_input, 1'b1};
			sync2_r <= sync1_r;
			tckLast_r <= sync2_r[4];
		end
	end
	wire trstNS = sync2_r[5];
	wire tckS = sync2_r[4];
	wire tmsS = sync2_r[3];
	wire tdiS = sync2_r[2];
	wire condS = sync2_r[1];
	wire tckRise = tckS & ~tckLast_r;
	wire tckFall = ~tckS & tckLast_r;

	reg [15:0] state_r;
	reg [15:0] state_nxt;
	reg [`IR_WIDTH-1:0] irShift_r;
	reg [`IR_WIDTH-1:0] irLatch_r;
	reg [`BSR_WIDTH-1:0] bsrShift_r;
	reg [`BSR_WIDTH-1:0] bsrOut_r;
	reg [`CTRL_WIDTH-1:0] ctrlShift_r;
	reg [`CNT_WIDTH-1:0] cntShift_r;
	reg [`CNT_WIDTH-1:0] cntPreload_r;
	reg [`IDB_WIDTH-1:0] idbShift_r;
	reg [`SEL_WIDTH-1:0] selShift_r;
	reg bypass_r;
	reg tdo_r;
	reg tdoOe_r;
	reg condPrev_r;
	reg [2:0] decSel;
	reg decTest;
	reg decCount;

	// Standard sixteen-state graph, stepped on each sampled rising edge
	always @*
	begin
		state_nxt = S_TLR;
		case (state_r)
			S_TLR: state_nxt = tmsS ? S_TLR : S_RTI;
			S_RTI: state_nxt = tmsS ? S_SDR : S_RTI;
			S_SDR: state_nxt = tmsS ? S_SIR : S_CDR;
			S_CDR: state_nxt = tmsS ? S_E1DR : S_SHDR;
			S_SHDR: state_nxt = tmsS ? S_E1DR : S_SHDR;
			S_E1DR: state_nxt = tmsS ? S_UDR : S_PDR;
			S_PDR: state_nxt = tmsS ? S_E2DR : S_PDR;
			S_E2DR: state_nxt = tmsS ? S_UDR : S_SHDR;
			S_UDR: state_nxt = tmsS ? S_SDR : S_RTI;
			S_SIR: state_nxt = tmsS ? S_TLR : S_CIR;
			S_CIR: state_nxt = tmsS ? S_E1IR : S_SHIR;
			S_SHIR: state_nxt = tmsS ? S_E1IR : S_SHIR;
			S_E1IR: state_nxt = tmsS ? S_UIR : S_PIR;
			S_PIR: state_nxt = tmsS ? S_E2IR : S_PIR;
			S_E2IR: state_nxt = tmsS ? S_UIR : S_SHIR;
			S_UIR: state_nxt = tmsS ? S_SDR : S_RTI;
			default: state_nxt = S_TLR;
		endcase
	end

	// Opcode decode of the latched instruction; anything unlisted is bypass
	always @*
	begin
		decSel = `DR_BYPASS;
		decTest = 1'b0;
		decCount = 1'b0;
		case (irLatch_r)
			`OP_EXTEST, `OP_INTEST:
			begin
				decSel = `DR_BOUNDARY;
				decTest = 1'b1;
			end
			`OP_SAMPLE: decSel = `DR_BOUNDARY;
			`OP_COUNT_A, `OP_COUNT_B: decCount = 1'b1;
			`OP_CTRL_A, `OP_CTRL_B: decSel = `DR_CONTROL;
			`OP_CNT_SCAN, `OP_CNT_READ: decSel = `DR_COUNTER;
			`OP_IDB_SCAN, `OP_IDB_READ: decSel = `DR_IDBUS;
			`OP_SEL_SCAN: decSel = `DR_SELECT;
			default: decSel = `DR_BYPASS;
		endcase
	end

	// Even parity over all eight bits: an odd count of ones is the error
	wire irOddParity = ^irShift_r;
	wire condActive = condS ~^ ctrlOut_r[`CTRL_DCI_POL_BIT];
	wire [`IR_WIDTH-1:0] statusWord = {parity_error_flag, 3'b000, condActive, 2'b00, 1'b1};
	wire fullReset = sys_rst | ~trstNS;

	reg selLsb;
	always @*
	begin
		selLsb = bypass_r;
		case (drSelect_r)
			`DR_BOUNDARY: selLsb = bsrShift_r[0];
			`DR_CONTROL: selLsb = ctrlShift_r[0];
			`DR_COUNTER: selLsb = cntShift_r[0];
			`DR_IDBUS: selLsb = idbShift_r[0];
			`DR_SELECT: selLsb = selShift_r[0];
			default: selLsb = bypass_r;
		endcase
	end

	wire bufInReady;
	wire irDone = tckRise & (state_r == S_UIR);

	always @(posedge ref_clk)
	begin
		if (fullReset)
		begin
			state_r <= S_TLR;
			irShift_r <= `IR_RESET_VALUE;
			irLatch_r <= `IR_RESET_VALUE;
			parity_error_flag <= 1'b0;
			bsrShift_r <= {`BSR_WIDTH{1'b0}};
			bsrOut_r <= {`BSR_WIDTH{1'b0}};
			ctrlShift_r <= `CTRL_RESET_VALUE;
			ctrlOut_r <= `CTRL_RESET_VALUE;
			cntShift_r <= {`CNT_WIDTH{1'b0}};
			cntPreload_r <= {`CNT_WIDTH{1'b0}};
			count_r <= {`CNT_WIDTH{1'b0}};
			idbShift_r <= {`IDB_WIDTH{1'b0}};
			selShift_r <= {`SEL_WIDTH{1'b0}};
			selOut_r <= {`SEL_WIDTH{1'b0}};
			bypass_r <= 1'b0;
			drSelect_r <= `DR_BYPASS;
			testMode_r <= 1'b0;
			countMode_r <= 1'b0;
			tdo_r <= 1'b1;
			tdoOe_r <= 1'b0;
			condPrev_r <= 1'b0;
		end
		else
		begin
			condPrev_r <= condActive;
			// Counter only steps on condition edges while idle
			if (countMode_r && state_r == S_RTI && condActive && !condPrev_r)
			begin
				if (ctrlOut_r[`CTRL_DIR_BIT])
					count_r <= count_r - 8'h01;
				else
					count_r <= count_r + 8'h01;
			end
			if (tckRise)
			begin
				state_r <= state_nxt;
				case (state_r)
					S_TLR:
					begin
						// Registers held at reset while in Test-Logic-Reset
						irLatch_r <= `IR_RESET_VALUE;
						drSelect_r <= `DR_BYPASS;
						testMode_r <= 1'b0;
						countMode_r <= 1'b0;
						ctrlOut_r <= `CTRL_RESET_VALUE;
						selOut_r <= {`SEL_WIDTH{1'b0}};
						parity_error_flag <= 1'b0;
					end
					S_CDR:
					begin
						case (drSelect_r)
							`DR_BOUNDARY: bsrShift_r <= {bsrOut_r[`BSR_WIDTH-1:`IDB_WIDTH], idBus};
							`DR_COUNTER: cntShift_r <= (irLatch_r == `OP_CNT_SCAN) ? count_r : cntPreload_r;
							`DR_IDBUS:
							begin
								if (irLatch_r == `OP_IDB_SCAN)
									idbShift_r <= idBus;
							end
							`DR_BYPASS: bypass_r <= 1'b0;
							default: bypass_r <= bypass_r;
						endcase
					end
					S_SHDR:
					begin
						// Shift happens leaving Shift-DR, including into Exit1-DR
						case (drSelect_r)
							`DR_BOUNDARY: bsrShift_r <= {tdiS, bsrShift_r[`BSR_WIDTH-1:1]};
							`DR_CONTROL: ctrlShift_r <= {tdiS, ctrlShift_r[`CTRL_WIDTH-1:1]};
							`DR_COUNTER: cntShift_r <= {tdiS, cntShift_r[`CNT_WIDTH-1:1]};
							`DR_IDBUS: idbShift_r <= {tdiS, idbShift_r[`IDB_WIDTH-1:1]};
							`DR_SELECT: selShift_r <= {tdiS, selShift_r[`SEL_WIDTH-1:1]};
							default: bypass_r <= tdiS;
						endcase
					end
					S_UDR:
					begin
						case (drSelect_r)
							`DR_BOUNDARY:
							begin
								if (testMode_r)
									bsrOut_r <= bsrShift_r;
							end
							`DR_CONTROL: ctrlOut_r <= ctrlShift_r;
							`DR_COUNTER:
							begin
								cntPreload_r <= cntShift_r;
								count_r <= cntShift_r;
							end
							`DR_SELECT: selOut_r <= selShift_r;
							default: bypass_r <= bypass_r;
						endcase
					end
					S_CIR: irShift_r <= statusWord;
					S_SHIR: irShift_r <= {tdiS, irShift_r[`IR_WIDTH-1:1]};
					S_UIR:
					begin
						// Only the shadow latches change here
						irLatch_r <= irShift_r;
						parity_error_flag <= irOddParity;
						drSelect_r <= decSelShift(irShift_r);
						testMode_r <= (irShift_r == `OP_EXTEST) || (irShift_r == `OP_INTEST);
						countMode_r <= (irShift_r == `OP_COUNT_A) || (irShift_r == `OP_COUNT_B);
					end
					default: state_r <= state_nxt;
				endcase
				// Clear on entry so logic is inactive by the fifth TMS-high edge
				if (state_nxt == S_TLR)
				begin
					irLatch_r <= `IR_RESET_VALUE;
					drSelect_r <= `DR_BYPASS;
					testMode_r <= 1'b0;
					countMode_r <= 1'b0;
					ctrlOut_r <= `CTRL_RESET_VALUE;
					selOut_r <= {`SEL_WIDTH{1'b0}};
					parity_error_flag <= 1'b0;
				end
			end
			if (tckFall)
			begin
				// The TDO output enable moves only on falling edges
				if (state_r == S_SHDR)
				begin
					tdoOe_r <= 1'b1;
					tdo_r <= selLsb;
				end
				else if (state_r == S_SHIR)
				begin
					tdoOe_r <= 1'b1;
					tdo_r <= irShift_r[0];
				end
				else
					tdoOe_r <= 1'b0;
			end
		end
	end

	// Decode helper for the value about to be latched
	function [2:0] decSelShift;
		input [`IR_WIDTH-1:0] op;
		begin
			case (op)
				`OP_EXTEST, `OP_INTEST, `OP_SAMPLE: decSelShift = `DR_BOUNDARY;
				`OP_CTRL_A, `OP_CTRL_B: decSelShift = `DR_CONTROL;
				`OP_CNT_SCAN, `OP_CNT_READ: decSelShift = `DR_COUNTER;
				`OP_IDB_SCAN, `OP_IDB_READ: decSelShift = `DR_IDBUS;
				`OP_SEL_SCAN: decSelShift = `DR_SELECT;
				default: decSelShift = `DR_BYPASS;
			endcase
		end
	endfunction

	// Condition output: parity error shown while in Pause-IR when so configured
	wire [1:0] condMode = ctrlOut_r[`CTRL_COND_MODE_HI:`CTRL_COND_MODE_LO];
	reg condRaw;
	always @*
	begin
		condRaw = 1'b0;
		case (condMode)
			2'b01: condRaw = parity_error_flag && (state_r == S_PIR) && !ctrlOut_r[`CTRL_MASK_PERR_BIT];
			2'b10: condRaw = ctrlOut_r[`CTRL_DIR_BIT] ? (count_r == 8'h00) : (count_r == 8'hFF);
			2'b11: condRaw = condActive;
			default: condRaw = 1'b0;
		endcase
	end
	wire condLevel = condRaw ~^ ctrlOut_r[`CTRL_COND_POL_BIT];
	reg condOut_r;
	reg condOe_r;
	always @(posedge ref_clk)
	begin
		if (fullReset)
		begin
			condOut_r <= 1'b0;
			condOe_r <= 1'b0;
		end
		else
		begin
			condOut_r <= condLevel;
			// Open drain drives only the low level unless the 3-state bit is set, then both levels are driven
			condOe_r <= ctrlOut_r[`CTRL_COND_EN_BIT] & (ctrlOut_r[`CTRL_COND_3ST_BIT] | ~condLevel);
		end
	end
	assign condition_output = condOut_r;
	assign conditionOutputOe = condOe_r;
	assign tdo = tdo_r;
	assign tdoOe = tdoOe_r;

	// Two-entry buffer carrying each newly loaded instruction out; a load arriving while both entries are full is dropped
	reg [`IR_WIDTH-1:0] buf0_r;
	reg [`IR_WIDTH-1:0] buf1_r;
	reg [1:0] bufCount_r;
	assign bufInReady = (bufCount_r != 2'd2);
	assign wordValid = (bufCount_r != 2'd0);
	assign wordData = buf0_r;
	wire pushW = irDone & bufInReady;
	wire popW = wordValid & wordReady;
	always @(posedge ref_clk)
	begin
		if (fullReset)
		begin
			buf0_r <= {`IR_WIDTH{1'b0}};
			buf1_r <= {`IR_WIDTH{1'b0}};
			bufCount_r <= 2'd0;
		end
		else
		begin
			if (popW)
			begin
				buf0_r <= (bufCount_r == 2'd2) ? buf1_r : irShift_r;
				if (pushW && bufCount_r == 2'd2)
					buf1_r <= irShift_r;
			end
			else if (pushW)
			begin
				if (bufCount_r == 2'd0)
					buf0_r <= irShift_r;
				else
					buf1_r <= irShift_r;
			end
			bufCount_r <= bufCount_r + {1'b0, pushW} - {1'b0, popW};
		end
	end

endmodule

// file: scan_tap_instruction_decoder_properties.sv
`timescale 1ns/1ps
module scan_tap_checker
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Scan pins
	input wire logic tck,
	input wire logic trstN,
	input wire logic tdo,
	input wire logic tdoOe,
	// Decode and stream
	input wire logic [2:0] drSelect_r,
	input wire logic testMode_r,
	input wire logic countMode_r,
	input wire logic wordValid,
	input wire logic wordReady,
	input wire logic [7:0] wordData
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	// Pin passes two sync flops before it acts
	sequence s_trstHeld;
		!trstN [*4];
	endsequence
	sequence s_stall;
		wordValid && !wordReady;
	endsequence
	property p_resetOut;
		disable iff (1'b0) sys_rst |=> !tdoOe && tdo && drSelect_r == 3'h0;
	endproperty
	a_resetOut: assert property (p_resetOut) else $error("outputs off after reset");
	property p_trst;
		s_trstHeld |=> drSelect_r == 3'h0 && !testMode_r && !tdoOe;
	endproperty
	a_trst: assert property (p_trst) else $error("test reset ignored");
	property p_testSel;
		testMode_r |-> drSelect_r == 3'h1;
	endproperty
	a_testSel: assert property (p_testSel) else $error("test mode without boundary");
	property p_countSel;
		countMode_r |-> drSelect_r == 3'h0 && !testMode_r;
	endproperty
	a_countSel: assert property (p_countSel) else $error("count mode without bypass");
	property p_oeFall;
		$changed(tdoOe) |-> !tck;
	endproperty
	a_oeFall: assert property (p_oeFall) else $error("output enable moved with clock high");
	property p_tdoFall;
		tdoOe && $changed(tdo) |-> !tck;
	endproperty
	a_tdoFall: assert property (p_tdoFall) else $error("serial out moved with clock high");
	property p_selChange;
		disable iff (sys_rst || !trstN) $changed(drSelect_r) |-> tck;
	endproperty
	a_selChange: assert property (p_selChange) else $error("select changed off a rising edge");
	property p_hold;
		s_stall |=> wordValid && $stable(wordData);
	endproperty
	a_hold: assert property (p_hold) else $error("stalled word lost");
	property p_wordRise;
		$rose(wordValid) |-> tck;
	endproperty
	a_wordRise: assert property (p_wordRise) else $error("word appeared off an update");
endmodule

bind scan_tap_instruction_decoder scan_tap_checker chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .tck(tck),
	.trstN(trstN), .tdo(tdo), .tdoOe(tdoOe), .drSelect_r(drSelect_r), .testMode_r(testMode_r),
	.countMode_r(countMode_r), .wordValid(wordValid), .wordReady(wordReady), .wordData(wordData));

// file: tb_scan_tap_instruction_decoder.sv
`timescale 1ns/1ps
module tb_scan_tap_instruction_decoder;
	logic ref_clk, sys_rst, trstN, condIn, wordReady, q, oe, prevErr;
	logic [3:0] idBus, got;
	logic [7:0] st, op;
	logic [7:0] fill [3];
	logic [4:0] e;
	wire tck, tms, tdi, tdo, tdoOe, wordValid, testMode, countMode, perr;
	wire [2:0] drSel;
	wire [7:0] wordData;
	int bad_count, checked;
	logic [7:0] ops [22] = '{8'h00, 8'h03, 8'h82, 8'h81, 8'h84, 8'h05, 8'h06, 8'h87, 8'h88, 8'h09, 8'h0A,
		8'h8B, 8'h0C, 8'h8D, 8'h8E, 8'h0F, 8'hFA, 8'h7B, 8'hFC, 8'h7D, 8'h7E, 8'h55};

	scan_bus_ctrl_model bus (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe));
	scan_tap_instruction_decoder dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
		.trstN(trstN), .tdo(tdo), .tdoOe(tdoOe), .condition_input(condIn), .condition_output(),
		.conditionOutputOe(), .idBus(idBus), .drSelect_r(drSel), .testMode_r(testMode), .countMode_r(countMode),
		.parity_error_flag(perr), .ctrlOut_r(), .selOut_r(), .count_r(), .wordValid(wordValid),
		.wordReady(wordReady), .wordData(wordData));

	initial
	begin
		ref_clk = 0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	function automatic logic [4:0] expDec(input logic [7:0] v);
		case (v)
			8'h00, 8'h03: expDec = 5'h06;
			8'h82: expDec = 5'h04;
			8'h88, 8'h09: expDec = 5'h01;
			8'h8E, 8'h0F: expDec = 5'h08;
			8'hFA, 8'h7B: expDec = 5'h0C;
			8'hFC, 8'h7D: expDec = 5'h10;
			8'h7E: expDec = 5'h14;
			default: expDec = 5'h00;
		endcase
	endfunction

	task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] g);
		checked++;
		if (g !== ex)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, g);
		end
	endtask

	task automatic walk(input logic [7:0] pat, input int n);
		for (int i = 0; i < n; i++)
			bus.step(pat[i], 1'b1, q, oe);
	endtask

	// Starts and ends in Run-Test/Idle; returns what was captured
	task automatic loadIr(input logic [7:0] v, output logic [7:0] s);
		walk(8'h03, 4);
		for (int i = 0; i < 8; i++)
		begin
			bus.step(i == 7, v[i], q, oe);
			s[i] = q;
			chk("tdoOe shift", 8'h01, {7'h0, oe});
		end
		bus.step(1'b1, 1'b1, q, oe);
		chk("tdoOe exit", 8'h00, {7'h0, oe});
		walk(8'h00, 1);
	endtask

	task automatic pop(input logic [7:0] v);
		@(posedge ref_clk);
		#2;
		chk("word valid", 8'h01, {7'h0, wordValid});
		chk("word data", v, wordData);
		wordReady = 1;
		@(posedge ref_clk);
		#2;
		wordReady = 0;
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		#1_000_000;
		bad_count++;
		results;
	end

	initial
	begin
		sys_rst = 1;
		trstN = 1;
		condIn = 0;
		wordReady = 0;
		idBus = 4'h0;
		bad_count = 0;
		checked = 0;
		prevErr = 0;
		void'($urandom(57780));
		repeat (12) @(posedge ref_clk);
		#2;
		sys_rst = 0;
		repeat (4) @(posedge ref_clk);
		#2;
		chk("select after reset", 8'h00, {5'h0, drSel});
		chk("tdoOe after reset", 8'h00, {7'h0, tdoOe});
		walk(8'h00, 1);
		$display("test reset done");
		for (int k = 0; k < 30; k++)
		begin
			op = (k < 22) ? ops[k] : 8'($urandom);
			condIn = 1'($urandom);
			loadIr(op, st);
			chk("status word", {prevErr, 3'h0, ~condIn, 3'h1}, st);
			prevErr = ^op;
			chk("parity flag", {7'h0, prevErr}, {7'h0, perr});
			e = expDec(op);
			if (!prevErr)
				chk("decode", {3'h0, e}, {3'h0, drSel, testMode, countMode});
			pop(op);
		end
		$display("test decode done");
		for (int k = 0; k < 3; k++)
		begin
			fill[k] = 8'($urandom);
			loadIr(fill[k], st);
		end
		pop(fill[0]);
		pop(fill[1]);
		@(posedge ref_clk);
		#2;
		chk("third word dropped", 8'h00, {7'h0, wordValid});
		$display("test buffer done");
		idBus = 4'($urandom);
		loadIr(8'hFC, st);
		pop(8'hFC);
		walk(8'h01, 3);
		for (int i = 0; i < 4; i++)
		begin
			bus.step(i == 3, 1'b0, q, oe);
			got[i] = q;
		end
		walk(8'h01, 2);
		chk("id bus scan", {4'h0, idBus}, {4'h0, got});
		$display("test idbus done");
		loadIr(8'h00, st);
		pop(8'h00);
		chk("test mode", 8'h01, {7'h0, testMode});
		walk(8'h09, 5);
		walk(8'h1F, 5);
		chk("tms reset select", 8'h00, {5'h0, drSel});
		chk("tms reset mode", 8'h00, {7'h0, testMode});
		walk(8'h00, 1);
		$display("test tms reset done");
		loadIr(8'h03, st);
		pop(8'h03);
		trstN = 0;
		repeat (10) @(posedge ref_clk);
		#2;
		chk("trst select", 8'h00, {5'h0, drSel});
		chk("trst mode", 8'h00, {7'h0, testMode});
		trstN = 1;
		repeat (4) @(posedge ref_clk);
		#2;
		walk(8'h00, 1);
		$display("test trst done");
		results;
	end
endmodule
